// ---- verilog/pic_pkg.sv ----
// Purpose: Shared constants for the prioritized interrupt controller
// Assumes: 16-bit register port, byte offsets as printed
// Notes:   Slot index equals the bit position in the in-service, request and mask registers
package pic_pkg;

  // Source slots: 0 timer, 2 dma0, 3 dma1, 4..7 ext a..d (master) or 4,5 timer1,2 (slave)
  localparam int          PIC_NSLOT        = 8;
  localparam logic [7:0]  PIC_SLOTS_MASTER = 8'hFD;
  localparam logic [7:0]  PIC_SLOTS_SLAVE  = 8'h3D;

  // Register offsets
  localparam logic [7:0]  PIC_OFF_VEC      = 8'h20;
  localparam logic [7:0]  PIC_OFF_EOI      = 8'h22;
  localparam logic [7:0]  PIC_OFF_POLL     = 8'h24;
  localparam logic [7:0]  PIC_OFF_POLLST   = 8'h26;
  localparam logic [7:0]  PIC_OFF_MASK     = 8'h28;
  localparam logic [7:0]  PIC_OFF_PRIMSK   = 8'h2A;
  localparam logic [7:0]  PIC_OFF_INSERV   = 8'h2C;
  localparam logic [7:0]  PIC_OFF_REQ      = 8'h2E;
  localparam logic [7:0]  PIC_OFF_STATUS   = 8'h30;
  localparam logic [7:0]  PIC_OFF_CTL_BASE = 8'h30;
  localparam logic [7:0]  PIC_OFF_CTL_TMR0 = 8'h32;
  localparam logic [7:0]  PIC_OFF_CTL_LAST = 8'h3E;
  localparam logic [7:0]  PIC_OFF_RELOC    = 8'hFE;

  // Field positions
  localparam int          PIC_DMA_HALT_FLAG_BIT     = 15;
  localparam int          PIC_SLAVE_BIT    = 14;
  localparam int          PIC_EOI_KIND_BIT = 15;
  localparam int          PIC_POLL_REQ_BIT = 15;
  localparam int          PIC_CTL_MSK_BIT  = 3;
  localparam int          PIC_CTL_LTM_BIT  = 4;
  localparam int          PIC_CTL_CAS_BIT  = 5;
  localparam int          PIC_CTL_SPECIAL_NESTING_SELECT_BIT = 6;
  localparam int          PIC_VEC_BASE_LSB = 3;

  // Encodings and reset values
  localparam logic [4:0]  PIC_TYPE_BASE    = 5'h08;
  localparam logic [2:0]  PIC_PR_RST       = 3'h7;
  localparam logic [2:0]  PIC_PRM_RST      = 3'h7;
  localparam logic [4:0]  PIC_VEC_RST      = 5'h00;

  typedef enum logic {PIC_MODE_MASTER, PIC_MODE_SLAVE} pic_mode_t;

endpackage : pic_pkg

// ---- verilog/pic_ctrl.sv ----
// Purpose: Prioritized interrupt controller, master and slave mode
// Assumes: Core acknowledge and register strobes are single-cycle, on clk_sys_i
// Notes:   Ext pins pass a two-flop synchroniser; all outputs are registered
// Notes on behaviour
// - Master status holds DMA halt flag at bit 15 and three timer request flags.
// - Internal control word holds priority and mask; mask shared with mask register.
// - Priority 000 is highest, 111 lowest.
// - Trigger select 1 means level, 0 edge; inputs active high.
// - Edge mode requests only after a rise; requester holds line until acknowledged.
// - Mask bit 1 blocks a source, 0 passes it.
// - External control words for inputs a and b carry cascade and special nesting select bits.
// - Cascade or special nesting makes third and fourth input controls ignored.
// - Master end command register is write-only; kind 1 nonspecific, 0 specific.
// - Specific end command clears in-service of the written vector type.
// - Poll read sets in-service of the top pending source.
// - Poll status read reports the same without setting in-service.
// - Poll reads return pending flag plus vector type of top requester.
// - Master mode after reset; relocation bit 14 selects slave mode.
// - Slave mode ignores external inputs; each timer gets its own slot.
// - Slave pins: a core irq in, b select in, c acknowledge out, d request out.
// - Slave acknowledge masks all levels below the acknowledged one.
// - Slave vector is five base bits from 20H plus three-bit level.
// - Slave write of level to 22H clears that level's in-service bit.
// - Slave in-service: DMA bits 2,3; timers bits 0,4,5.
// - Slave request bits set by source, cleared on acknowledge; only DMA writable.
// - Reset sets priorities 111, masks set, other bits clear, master mode.
//
// The plain strobed port is this design's own decision.
module pic_ctrl
  import pic_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rstn_i,
  // Register port
  input  wire logic [7:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [15:0] rdata_o,
  // Internal sources, one-cycle events
  input  wire logic [2:0]  timer_evt_i,
  input  wire logic [1:0]  dma_evt_i,
  // Core side
  input  wire logic        inta_i,
  output logic             cpu_irq_o,
  output logic      [7:0]  vec_o,
  output logic             vec_valid_o,
  // External pins
  input  wire logic        ext_request_a_i,
  input  wire logic        ext_request_b_i,
  input  wire logic        ext_request_c_i,
  input  wire logic        ext_request_d_i,
  output logic             ext_request_c_o,
  output logic             ext_request_c_oe_o,
  output logic             ext_request_d_o,
  output logic             ext_request_d_oe_o,
  // Status
  output logic             dma_halt_o,
  output logic             slave_mode_o
);

  // Control slot decode from address, used by write and read paths
  function automatic logic [3:0] pic_ctl_slot(input logic [7:0] a, input logic [7:0] used);
    logic [2:0] s;
    logic       hit;
    s   = (a[3:1] == 3'h1) ? 3'h0 : a[3:1]; // Timer word sits at 32H but owns slot 0
    hit = (a >= PIC_OFF_CTL_TMR0) && (a <= PIC_OFF_CTL_LAST) && !a[0] && used[s];
    return {hit, s};
  endfunction : pic_ctl_slot

  pic_mode_t   mode_q;
  logic        slave;
  logic [7:0]  used;
  logic [3:0]  ctl_hit;
  logic [2:0]  pr_q   [PIC_NSLOT];
  logic [7:0]  msk_q, ltm_q, cas_q, special_nesting_select_q;
  logic [7:0]  is_q, is_d, req;
  logic [1:0]  dreq_q;
  logic [2:0]  irt_q;
  logic        dma_halt_flag_q;
  logic [2:0]  prm_q;
  logic [4:0]  vbase_q;
  logic [3:0]  sync1_q, sync2_q, prev_q, rise, edge_q;
  logic        best_valid;
  logic [2:0]  best_slot, best_pr;
  logic        is_any;
  logic [2:0]  is_top, is_min;
  logic        ack_go;
  logic        poll_rd;
  logic        ext_ignore;
  logic [15:0] rd_val;
  logic        wr_eoi;

  assign slave   = (mode_q == PIC_MODE_SLAVE);
  assign used    = slave ? PIC_SLOTS_SLAVE : PIC_SLOTS_MASTER;
  assign ctl_hit = pic_ctl_slot(addr_i, used);
  assign poll_rd = rd_i && (addr_i == PIC_OFF_POLL);
  assign wr_eoi  = wr_i && (addr_i == PIC_OFF_EOI);
  assign rise    = sync2_q & ~prev_q; // Synced low-to-high per pin
  assign ext_ignore = cas_q[4] | cas_q[5] | special_nesting_select_q[4] | special_nesting_select_q[5];

  // Mode select, master after reset
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      mode_q <= PIC_MODE_MASTER;
    end else if (wr_i && addr_i == PIC_OFF_RELOC) begin
      mode_q <= wdata_i[PIC_SLAVE_BIT] ? PIC_MODE_SLAVE : PIC_MODE_MASTER;
    end
  end

  // Pin synchroniser; only stage two feeds logic
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
      prev_q  <= 4'h0;
    end else begin
      sync1_q <= {ext_request_d_i, ext_request_c_i, ext_request_b_i, ext_request_a_i};
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  // Per-slot priority and mask; the mask register reaches the same bits
  for (genvar s = 0; s < PIC_NSLOT; s++) begin : g_slot
    always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
        pr_q[s]  <= PIC_PR_RST;
        msk_q[s] <= 1'b1;
      end else if (wr_i && ctl_hit[3] && ctl_hit[2:0] == 3'(s)) begin
        pr_q[s]  <= wdata_i[2:0];
        msk_q[s] <= wdata_i[PIC_CTL_MSK_BIT];
      end else if (wr_i && addr_i == PIC_OFF_MASK && used[s]) begin
        msk_q[s] <= wdata_i[s];
      end
    end
  end

  // Ext trigger, cascade and nesting bits; frozen in slave mode, where pins change role
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      ltm_q  <= 8'h00;
      cas_q  <= 8'h00;
      special_nesting_select_q <= 8'h00;
    end else if (wr_i && ctl_hit[3] && ctl_hit[2] && !slave) begin
      ltm_q[ctl_hit[2:0]] <= wdata_i[PIC_CTL_LTM_BIT];
      if (!ctl_hit[1]) begin
        cas_q[ctl_hit[2:0]]  <= wdata_i[PIC_CTL_CAS_BIT];
        special_nesting_select_q[ctl_hit[2:0]] <= wdata_i[PIC_CTL_SPECIAL_NESTING_SELECT_BIT];
      end
    end
  end

  // Edge latches; set wins over the ack clear, so a rise in the ack cycle is kept
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      edge_q <= 4'h0;
    end else begin
      for (int k = 4; k < PIC_NSLOT; k++) begin
        if (rise[k-4]) begin
          edge_q[k-4] <= 1'b1;
        end else if (ack_go && best_slot == 3'(k)) begin
          edge_q[k-4] <= 1'b0;
        end
      end
    end
  end

  // Timer flags: event set wins over clear
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      irt_q  <= 3'h0;
      dma_halt_flag_q <= 1'b0;
    end else begin
      if (wr_i && addr_i == PIC_OFF_STATUS) begin
        irt_q  <= wdata_i[2:0] | timer_evt_i;
        dma_halt_flag_q <= wdata_i[PIC_DMA_HALT_FLAG_BIT] && !slave;
      end else begin
        irt_q[0] <= timer_evt_i[0] | (irt_q[0] & !(slave && ack_go && best_slot == 3'd0));
        irt_q[1] <= timer_evt_i[1] | (irt_q[1] & !(slave && ack_go && best_slot == 3'd4));
        irt_q[2] <= timer_evt_i[2] | (irt_q[2] & !(slave && ack_go && best_slot == 3'd5));
      end
    end
  end

  // DMA request bits, software writable
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      dreq_q <= 2'h0;
    end else if (wr_i && addr_i == PIC_OFF_REQ) begin
      dreq_q <= wdata_i[3:2] | dma_evt_i;
    end else begin
      dreq_q[0] <= dma_evt_i[0] | (dreq_q[0] & !(ack_go && best_slot == 3'd2));
      dreq_q[1] <= dma_evt_i[1] | (dreq_q[1] & !(ack_go && best_slot == 3'd3));
    end
  end

  // Priority mask and slave vector base
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      prm_q   <= PIC_PRM_RST;
      vbase_q <= PIC_VEC_RST;
    end else if (wr_i && addr_i == PIC_OFF_PRIMSK) begin
      prm_q <= wdata_i[2:0];
    end else if (wr_i && addr_i == PIC_OFF_VEC && slave) begin
      vbase_q <= wdata_i[7:PIC_VEC_BASE_LSB];
    end
  end

  // Raw request per slot
  always_comb begin
    req    = 8'h00;
    req[0] = slave ? irt_q[0] : |irt_q;
    req[2] = dreq_q[0];
    req[3] = dreq_q[1];
    if (slave) begin
      req[4] = irt_q[1];
      req[5] = irt_q[2];
    end else begin
      for (int k = 4; k < PIC_NSLOT; k++) begin
        req[k] = ltm_q[k] ? sync2_q[k-4] : edge_q[k-4];
      end
      if (ext_ignore) begin
        req[6] = 1'b0;
        req[7] = 1'b0;
      end
    end
  end

  // Resolve top pending source and top in-service source
  always_comb begin
    logic ok;
    ok         = 1'b0;
    is_any     = 1'b0;
    is_top     = 3'd0;
    is_min     = 3'h7;
    best_valid = 1'b0;
    best_slot  = 3'd0;
    best_pr    = 3'h7;
    for (int s = 0; s < PIC_NSLOT; s++) begin
      if (is_q[s] && used[s] && (!is_any || pr_q[s] < is_min)) begin
        is_any = 1'b1;
        is_top = 3'(s);
        is_min = pr_q[s];
      end
    end
    for (int s = 0; s < PIC_NSLOT; s++) begin
      ok = req[s] && used[s] && !msk_q[s] && (pr_q[s] <= prm_q);
      // Slave nesting and special nesting let equal levels through
      ok = ok && (!is_any || pr_q[s] < is_min ||
                  (pr_q[s] == is_min && (slave || special_nesting_select_q[s])));
      if (ok && (!best_valid || pr_q[s] < best_pr)) begin
        best_valid = 1'b1;
        best_slot  = 3'(s);
        best_pr    = pr_q[s];
      end
    end
  end

  // Acknowledge: core cycle (slave needs select) or poll read
  assign ack_go = best_valid && ((inta_i && (!slave || sync2_q[1])) || poll_rd);

  // In-service next value; set wins over clear
  always_comb begin
    is_d = is_q;
    if (wr_i && addr_i == PIC_OFF_INSERV) begin
      is_d = wdata_i[7:0] & used;
    end else if (wr_eoi && !slave) begin
      if (wdata_i[PIC_EOI_KIND_BIT]) begin
        if (is_any) begin
          is_d[is_top] = 1'b0;
        end
      end else if (wdata_i[4:3] == PIC_TYPE_BASE[4:3]) begin
        is_d[wdata_i[2:0]] = 1'b0;
      end
    end else if (wr_eoi && slave) begin
      for (int s = 0; s < PIC_NSLOT; s++) begin
        if (used[s] && pr_q[s] == wdata_i[2:0]) begin
          is_d[s] = 1'b0;
        end
      end
    end
    if (ack_go) begin
      is_d[best_slot] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      is_q <= 8'h00;
    end else begin
      is_q <= is_d;
    end
  end

  // Register read mux
  always_comb begin
    rd_val = 16'h0000;
    if (ctl_hit[3]) begin
      rd_val[2:0]              = pr_q[ctl_hit[2:0]];
      rd_val[PIC_CTL_MSK_BIT]  = msk_q[ctl_hit[2:0]];
      rd_val[PIC_CTL_LTM_BIT]  = ltm_q[ctl_hit[2:0]];
      rd_val[PIC_CTL_CAS_BIT]  = cas_q[ctl_hit[2:0]];
      rd_val[PIC_CTL_SPECIAL_NESTING_SELECT_BIT] = special_nesting_select_q[ctl_hit[2:0]];
    end else begin
      case (addr_i)
        PIC_OFF_POLL, PIC_OFF_POLLST: begin
          rd_val[PIC_POLL_REQ_BIT] = best_valid;
          rd_val[4:0]              = best_valid ? (PIC_TYPE_BASE + 5'(best_slot)) : 5'h00;
        end
        PIC_OFF_MASK:   rd_val[7:0] = msk_q & used;
        PIC_OFF_PRIMSK: rd_val[2:0] = prm_q;
        PIC_OFF_INSERV: rd_val[7:0] = is_q & used;
        PIC_OFF_REQ:    rd_val[7:0] = req & used;
        PIC_OFF_STATUS: rd_val      = {dma_halt_flag_q, 12'h000, irt_q};
        PIC_OFF_VEC:    rd_val[7:0] = slave ? {vbase_q, 3'h0} : 8'h00;
        PIC_OFF_RELOC:  rd_val[PIC_SLAVE_BIT] = slave;
        default:        rd_val      = 16'h0000; // MASTER_SERVICE_END_COMMAND is write-only, reads zero
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      rdata_o <= 16'h0000;
    end else begin
      rdata_o <= rd_i ? rd_val : 16'h0000;
    end
  end

  // Core side: request level and vector answer
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      cpu_irq_o   <= 1'b0;
      vec_o       <= 8'h00;
      vec_valid_o <= 1'b0;
    end else begin
      cpu_irq_o   <= slave ? sync2_q[0] : best_valid;
      vec_valid_o <= ack_go && inta_i;
      if (ack_go && inta_i) begin
        vec_o <= slave ? {vbase_q, best_pr} : {3'h0, PIC_TYPE_BASE + 5'(best_slot)};
      end
    end
  end

  // Slave pins c and d turn to outputs; c pulses on core acknowledge
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      ext_request_c_o    <= 1'b0;
      ext_request_c_oe_o <= 1'b0;
      ext_request_d_o    <= 1'b0;
      ext_request_d_oe_o <= 1'b0;
      dma_halt_o         <= 1'b0;
      slave_mode_o       <= 1'b0;
    end else begin
      ext_request_c_o    <= slave && inta_i;
      ext_request_c_oe_o <= slave;
      ext_request_d_o    <= slave && best_valid;
      ext_request_d_oe_o <= slave;
      dma_halt_o         <= dma_halt_flag_q;
      slave_mode_o       <= slave;
    end
  end

endmodule : pic_ctrl

// ---- tb/pic_ctrl_assertions.sv ----
// Purpose: Port-level assertions for pic_ctrl
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound to every pic_ctrl instance
module pic_ctrl_chk
  import pic_pkg::*;
(
  // Observed ports
  input wire logic        clk_sys_i,
  input wire logic        rstn_i,
  input wire logic [7:0]  addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [15:0] rdata_o,
  input wire logic        inta_i,
  input wire logic [7:0]  vec_o,
  input wire logic        vec_valid_o,
  input wire logic        ext_request_c_o,
  input wire logic        ext_request_c_oe_o,
  input wire logic        ext_request_d_oe_o,
  input wire logic        dma_halt_o,
  input wire logic        slave_mode_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Everything sampled on the system clock
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);

  property p_rd_idle; !$past(rd_i) |-> rdata_o == 16'h0000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  property p_wo; $past(rd_i && addr_i == PIC_OFF_EOI) |-> rdata_o == 16'h0000; endproperty
  a_wo: assert property (p_wo) else $error("end command register readable");
  property p_poll; $past(rd_i && addr_i == PIC_OFF_POLLST) |-> rdata_o[14:5] == 10'h000; endproperty
  a_poll: assert property (p_poll) else $error("poll status reserved bits set");
  property p_ack; vec_valid_o |-> $past(inta_i); endproperty
  a_ack: assert property (p_ack) else $error("vector without acknowledge");
  property p_mvec; vec_valid_o && !slave_mode_o |-> vec_o[7:3] == 5'h01; endproperty
  a_mvec: assert property (p_mvec) else $error("master vector type out of range");
  // Mode and halt flag pass a register and then the output flop: two cycles
  property p_mode; wr_i && addr_i == PIC_OFF_RELOC && wdata_i[PIC_SLAVE_BIT] |=> ##1 slave_mode_o; endproperty
  a_mode: assert property (p_mode) else $error("slave mode not entered");
  property p_halt;
    wr_i && addr_i == PIC_OFF_STATUS && !slave_mode_o |-> ##2 dma_halt_o == $past(wdata_i[PIC_DMA_HALT_FLAG_BIT], 2);
  endproperty
  a_halt: assert property (p_halt) else $error("halt flag not written");
  property p_sack; slave_mode_o && vec_valid_o |-> ext_request_c_o && ext_request_c_oe_o; endproperty
  a_sack: assert property (p_sack) else $error("no acknowledge pulse to master");
  property p_moe; !slave_mode_o && $past(!slave_mode_o) |-> !ext_request_c_oe_o && !ext_request_d_oe_o; endproperty
  a_moe: assert property (p_moe) else $error("pins driven in master mode");
endmodule : pic_ctrl_chk

bind pic_ctrl pic_ctrl_chk i_chk (.clk_sys_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .inta_i,
  .vec_o, .vec_valid_o, .ext_request_c_o, .ext_request_c_oe_o, .ext_request_d_oe_o, .dma_halt_o, .slave_mode_o);

// ---- tb/pic_far_end.sv ----
// Purpose: External master controller on the slave-mode pins
// Assumes: Cascade select decoded outside without delay
// Notes:   Slow setting adds one cycle of answer latency
module pic_far_end (
  // Clock and reset
  input  wire logic clk_sys_i,
  input  wire logic rstn_i,
  input  wire logic slow_i,
  // Slave-side pins
  input  wire logic slave_req_i,
  input  wire logic slave_req_oe_i,
  output logic      core_irq_o,
  output logic      select_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic req_q;
  // Forward the slave request to the core and select the slave
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      req_q      <= 1'b0;
      core_irq_o <= 1'b0;
      select_o   <= 1'b0;
    end else begin
      req_q      <= slave_req_i && slave_req_oe_i;
      core_irq_o <= slow_i ? req_q : slave_req_i && slave_req_oe_i;
      select_o   <= slow_i ? req_q : slave_req_i && slave_req_oe_i;
    end
  end
endmodule : pic_far_end

// ---- tb/prioritized_interrupt_controller_tb.sv ----
// Purpose: Register-level tests of pic_ctrl in both modes
// Assumes: Register reads answer one cycle after the strobe
// Notes:   Ext inputs pass a synchroniser, so waits allow 5 cycles
module prioritized_interrupt_controller_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i, rstn_i, wr_i, rd_i, inta_i, ext_c, far_irq, far_sel;
  logic cpu_irq_o, vec_valid_o, c_o, c_oe, d_o, d_oe, dma_halt_o, slave_mode_o;
  logic [7:0] addr_i, vec_o;
  logic [15:0] wdata_i, rdata_o;
  logic [2:0] timer_evt_i;
  logic [1:0] dma_evt_i;
  int n_mismatch, tests_run, cycles;

  pic_ctrl i_dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .timer_evt_i(timer_evt_i), .dma_evt_i(dma_evt_i), .inta_i(inta_i),
    .cpu_irq_o(cpu_irq_o), .vec_o(vec_o), .vec_valid_o(vec_valid_o),
    .ext_request_a_i(slave_mode_o & far_irq), .ext_request_b_i(slave_mode_o & far_sel),
    .ext_request_c_i(ext_c), .ext_request_d_i(1'b0), .ext_request_c_o(c_o), .ext_request_c_oe_o(c_oe),
    .ext_request_d_o(d_o), .ext_request_d_oe_o(d_oe), .dma_halt_o(dma_halt_o), .slave_mode_o(slave_mode_o));
  pic_far_end i_far (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .slow_i(1'b1), .slave_req_i(d_o),
    .slave_req_oe_i(d_oe), .core_irq_o(far_irq), .select_o(far_sel));

  // 50 MHz clock
  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  task automatic close_out;
    $display("compares %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge clk_sys_i);
    wr_i    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk_sys_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge clk_sys_i);
    rd_i   <= 1'b0;
    #1 chk(rdata_o, exp);
  endtask : rd

  task automatic evt(input logic [2:0] t, input logic [1:0] d);
    @(posedge clk_sys_i);
    timer_evt_i <= t;
    dma_evt_i   <= d;
    @(posedge clk_sys_i);
    timer_evt_i <= 3'h0;
    dma_evt_i   <= 2'h0;
  endtask : evt

  // Core acknowledge once the interrupt line is up; bounded wait.
  // Settle first: a stale slave-mode line needs cycles to fall through far end and synchroniser
  task automatic ack(input logic [7:0] v);
    repeat (8) @(posedge clk_sys_i);
    for (int i = 0; i < 20 && cpu_irq_o !== 1'b1; i++) @(posedge clk_sys_i);
    @(posedge clk_sys_i);
    inta_i <= 1'b1;
    @(posedge clk_sys_i);
    inta_i <= 1'b0;
    #1 chk({7'h00, vec_valid_o, vec_o}, {8'h01, v});
  endtask : ack

  // Watchdog; whole run needs well under 1000 cycles
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t timeout", $time);
      close_out();
    end
  end

  initial begin
    {rstn_i, wr_i, rd_i, inta_i, ext_c, addr_i, wdata_i, timer_evt_i, dma_evt_i} = '0;
    repeat (3) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    rd(8'h28, 16'h00FD);
    rd(8'h2A, 16'h0007);
    rd(8'h32, 16'h000F);
    rd(8'h3E, 16'h000F);
    rd(8'h2C, 16'h0000);
    // Shared mask storage, both directions
    wr(8'h32, 16'h0002);
    rd(8'h28, 16'h00FC);
    wr(8'h28, 16'h00FD);
    rd(8'h32, 16'h000A);
    wr(8'h28, 16'h00FC);
    // Timer: status read leaves service alone, poll acknowledges
    evt(3'h1, 2'h0);
    rd(8'h26, 16'h8008);
    rd(8'h2C, 16'h0000);
    rd(8'h24, 16'h8008);
    rd(8'h2C, 16'h0001);
    rd(8'h30, 16'h0001);
    wr(8'h30, 16'h8000);
    rd(8'h30, 16'h8000);
    wr(8'h30, 16'h0000);
    // Higher priority DMA nests over the timer in service
    wr(8'h34, 16'h0001);
    evt(3'h0, 2'h1);
    rd(8'h26, 16'h800A);
    wr(8'h22, 16'h0008);
    rd(8'h2C, 16'h0000);
    rd(8'h22, 16'h0000);
    rd(8'h10, 16'h0000);
    wr(8'h34, 16'h0009);
    rd(8'h2E, 16'h0004);
    rd(8'h26, 16'h0000);
    wr(8'h2E, 16'h0000);
    rd(8'h2E, 16'h0000);
    // External input c, edge then level, then suppressed by cascade
    wr(8'h3C, 16'h0000);
    ext_c <= 1'b1;
    repeat (5) @(posedge clk_sys_i);
    rd(8'h26, 16'h800E);
    ack(8'h0E);
    wr(8'h22, 16'h8000);
    rd(8'h2C, 16'h0000);
    rd(8'h26, 16'h0000);
    wr(8'h3C, 16'h0010);
    rd(8'h26, 16'h800E);
    wr(8'h38, 16'h0028);
    rd(8'h26, 16'h0000);
    ext_c <= 1'b0;
    wr(8'h3C, 16'h000F);
    $display("master tests done");
    // Slave mode with distinct priorities for the slot 0 timer and both DMA sources; mode output lags the write by a cycle
    wr(8'hFE, 16'h4000);
    @(posedge clk_sys_i);
    #1 chk({15'h0000, slave_mode_o}, 16'h0001);
    wr(8'h20, 16'h0028);
    wr(8'h32, 16'h0003);
    wr(8'h34, 16'h000A);
    wr(8'h36, 16'h0001);
    evt(3'h1, 2'h0);
    ack(8'h2B);
    rd(8'h2C, 16'h0001);
    rd(8'h2E, 16'h0000);
    evt(3'h0, 2'h2);
    ack(8'h29);
    rd(8'h2C, 16'h0009);
    evt(3'h1, 2'h0);
    repeat (6) @(posedge clk_sys_i);
    #1 chk({15'h0000, d_o}, 16'h0000);
    wr(8'h22, 16'h0001);
    rd(8'h2C, 16'h0001);
    ack(8'h2B);
    $display("slave tests done");
    close_out();
  end
endmodule : prioritized_interrupt_controller_tb
